//--- dv/xcvr_fab_properties.sv
`timescale 1ns/1ps
`default_nettype none
module xcvr_fab_chk
   import xcvr_ctrl_pkg::*;
#(
   parameter bit PCIE_MODE  = 1'b1,
   parameter bit EI_INFER   = 1'b0,
   parameter bit RATE_MATCH = 1'b0,
   parameter int BOND       = 1
) (
   input wire logic aclk,           // Clock
   input wire logic aresetn,        // Reset, low
   input wire logic force_ltd,      // Force data lock
   input wire logic force_ltr,      // Force ref lock
   input wire logic cdr_ltd_mode,   // Mode flag
   input wire logic cdr_ref_locked, // Ref lock flag
   input wire logic sig_detect,     // Signal present
   input wire logic elec_idle,      // Idle flag
   input wire logic pll_pd,         // PLL off
   input wire logic pll_locked,     // PLL lock
   input wire logic ord_en,         // Ordering enable
   input wire logic ord_done,       // Ordering found
   input wire logic rx_dig_reset,   // PCS reset
   input wire logic rx_fifo_err,    // FIFO full/empty
   input wire logic rx_valid,       // Word out
   input wire logic tx_compliance,  // Compliance pulse
   input wire logic rx_clk_avail,   // Rx clock flag
   input wire logic bond_clk_avail  // Bond clock flag
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // CLK_DATA_RECOVERY mode and lock
   property p_force_ltd;
      force_ltd |=> cdr_ltd_mode;
   endproperty
   a_force_ltd: assert property (p_force_ltd)
      else $error("forced data lock not shown");
   property p_force_ltr;
      !force_ltd && force_ltr |=> !cdr_ltd_mode;
   endproperty
   a_force_ltr: assert property (p_force_ltr)
      else $error("forced reference lock not shown");
   property p_auto;
      !force_ltd && !force_ltr |=> cdr_ltd_mode == cdr_ref_locked;
   endproperty
   a_auto: assert property (p_auto)
      else $error("automatic mode does not follow lock");
   // Past reset guard: both flags sit at zero in the first cycle
   property p_eidle;
      $past(aresetn) |-> elec_idle == (PCIE_MODE && !EI_INFER && !sig_detect);
   endproperty
   a_eidle: assert property (p_eidle)
      else $error("idle flag not inverse of detect");
   property p_pll_pd;
      pll_pd |=> !pll_locked;
   endproperty
   a_pll_pd: assert property (p_pll_pd)
      else $error("lock shown while powered down");

   // ==========================================================
   // Receive PCS
   property p_rx_rst;
      rx_dig_reset |=> rx_fifo_err && !rx_valid && !ord_done;
   endproperty
   a_rx_rst: assert property (p_rx_rst)
      else $error("receive reset did not clear");
   property p_ord_restart;
      $rose(ord_en) |=> !ord_done;
   endproperty
   a_ord_restart: assert property (p_ord_restart)
      else $error("ordering not restarted");
   property p_ord_hold;
      ord_done && !rx_dig_reset && !$rose(ord_en) |=> ord_done;
   endproperty
   a_ord_hold: assert property (p_ord_hold)
      else $error("ordering status dropped");
   property p_cmp_pulse;
      tx_compliance |=> !tx_compliance;
   endproperty
   a_cmp_pulse: assert property (p_cmp_pulse)
      else $error("compliance held too long");
   property p_avail;
      rx_clk_avail == !RATE_MATCH && bond_clk_avail == (BOND >= BOND_MIN);
   endproperty
   a_avail: assert property (p_avail)
      else $error("clock availability wrong");

   c_found: cover property ($rose(ord_done));
   c_burst: cover property (rx_valid ##1 rx_valid);
   c_ltd: cover property (force_ltd ##1 cdr_ltd_mode);
endmodule
`default_nettype wire

//--- dv/xcvr_rx_fabric_ctrl_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module xcvr_rx_fabric_ctrl_status_tb_top
   import xcvr_ctrl_pkg::*;
;
   localparam int DW = 16;
   localparam int BW = 2;
   logic          aclk = 1'b0;
   logic          aresetn = 1'b0;
   logic [DW-1:0] pma_data = '0;
   logic [BW-1:0] pma_disp = '0;
   logic          pma_valid = 1'b0;
   logic          pma_ref_lock = 1'b0;
   logic          pma_sig_above = 1'b0;
   logic          pll_lock_raw = 1'b0;
   logic [7:0]    awaddr = '0, araddr = '0;
   logic [31:0]   wdata = '0, rdata, rd;
   logic [3:0]    wstrb = 4'hf;
   logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic          awready, wready, bvalid, arready, rvalid;
   logic [1:0]    bresp, rresp, rsp, kk, pstate_out;
   logic          cdr_ltd_sel, lpbk_sel, pll_pd_out, tx_neg_disp, tx_idle_out;
   logic [BW+DW-1:0] rxq[$];
   int            miscompares = 0, checks_done = 0, cyc = 0, neg_cnt = 0;
   int            base;
   logic [4:0]    v5;

   always #2.5 aclk = ~aclk;

   xcvr_fab_if #(.CH_W(8), .NCH(2)) fab_if ();
   xcvr_rx_dev #(.CH_W(8), .NCH(2)) u_xcvr_rx_dev (
      .aclk(aclk), .aresetn(aresetn), .fab(fab_if), .pma_data(pma_data),
      .pma_disp(pma_disp), .pma_valid(pma_valid), .pma_ref_lock(pma_ref_lock),
      .pma_sig_above(pma_sig_above), .pll_lock_raw(pll_lock_raw),
      .cdr_ltd_sel(cdr_ltd_sel), .lpbk_sel(lpbk_sel), .pll_pd_out(pll_pd_out),
      .pstate_out(pstate_out), .tx_neg_disp(tx_neg_disp),
      .tx_idle_out(tx_idle_out));
   xcvr_fab_ctrl u_xcvr_fab_ctrl (
      .aclk(aclk), .aresetn(aresetn), .fab(fab_if), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   xcvr_fab_chk u_xcvr_fab_chk (
      .aclk(aclk), .aresetn(aresetn), .force_ltd(fab_if.force_ltd),
      .force_ltr(fab_if.force_ltr), .cdr_ltd_mode(fab_if.cdr_ltd_mode),
      .cdr_ref_locked(fab_if.cdr_ref_locked), .sig_detect(fab_if.sig_detect),
      .elec_idle(fab_if.elec_idle), .pll_pd(fab_if.pll_pd),
      .pll_locked(fab_if.pll_locked), .ord_en(fab_if.ord_en),
      .ord_done(fab_if.ord_done), .rx_dig_reset(fab_if.rx_dig_reset),
      .rx_fifo_err(fab_if.rx_fifo_err), .rx_valid(fab_if.rx_valid),
      .tx_compliance(fab_if.tx_compliance),
      .rx_clk_avail(fab_if.rx_clk_avail),
      .bond_clk_avail(fab_if.bond_clk_avail));

   // ==========================================================
   // Monitor and watchdog
   always @(posedge aclk) begin
      cyc++;
      if (fab_if.rx_valid === 1'b1)
         rxq.push_back({fab_if.rx_run_disp, fab_if.rx_data});
      if (tx_neg_disp === 1'b1)
         neg_cnt++;
      if (cyc == 5000) begin
         miscompares++;
         stop_test();
      end
   end

   // ==========================================================
   // Bus tasks
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (!(awready && wready)) @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge aclk);
      while (!bvalid) @(posedge aclk);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (!rvalid) @(posedge aclk);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Status lags its cause by a register, so let two edges pass
   task automatic stat();
      repeat (2) @(posedge aclk);
      axi_rd(REG_STATUS);
   endtask

   // Valid stays up between pushes; caller drops it
   task automatic push(input logic [DW-1:0] d, input logic [BW-1:0] p);
      pma_data <= d;
      pma_disp <= p;
      pma_valid <= 1'b1;
      @(posedge aclk);
   endtask

   function automatic logic [DW-1:0] pat(input int i);
      pat = 16'ha030 + 16'(i) * 16'h0101;
   endfunction

   task automatic stop_test();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      stat();
      `CHK("idle status", 10'h1d0, rd[9:0])
      axi_wr(8'h10, 32'h1);
      `CHK("unmapped write", RESP_SLVERR, rsp)
      for (int m = 0; m < 8; m++) begin
         pma_ref_lock <= m[2];
         pma_sig_above <= m[2];
         pll_lock_raw <= m[2];
         axi_wr(REG_CTRL, 32'h200 | m[1:0]);
         stat();
         v5 = {!m[2], m[2], m[2], m[0] | (!m[1] & m[2]), m[2]};
         `CHK("cdr status", v5, rd[4:0])
         `CHK("cdr select", m[0] | (!m[1] & m[2]), cdr_ltd_sel)
      end
      for (int k = 0; k < 4; k++) begin
         kk = k[1:0];
         axi_wr(REG_CTRL, 32'h200 | {kk[0], kk, kk[1], kk[0], 2'b00});
         stat();
         v5 = {pstate_out, lpbk_sel, pll_pd_out, tx_idle_out};
         `CHK("tx ctrl", {kk, kk[0], kk}, v5)
         `CHK("pll lock", !kk[1], rd[S_PLL_LOCK])
      end
      base = neg_cnt;
      axi_wr(REG_CMD, 32'h1);
      repeat (3) @(posedge aclk);
      `CHK("compliance", base + 1, neg_cnt)
      // Stalled fabric: fill past depth, excess words are dropped
      axi_wr(REG_CTRL, 32'h0);
      rxq.delete();
      for (int i = 0; i < 6; i++) begin
         push(pat(i), i[1:0]);
         pma_valid <= 1'b0;
         stat();
         `CHK("fifo flag", i >= 3, rd[S_FIFO_ERR])
      end
      axi_wr(REG_CTRL, 32'h200);
      repeat (8) @(posedge aclk);
      `CHK("drained", FIFO_DEPTH_DEF, rxq.size())
      for (int i = 0; i < 4; i++)
         `CHK("rx word", {i[1:0], pat(i)}, rxq[i])
      stat();
      `CHK("fifo empty", 1'b1, rd[S_FIFO_ERR])
      axi_rd(REG_DATA);
      `CHK("last word", 32'h0000a333, rd)
      // Pattern in the upper byte must not count
      axi_wr(REG_CTRL, 32'h300);
      push({ORD_PAT_DEF, 8'h5a}, 2'b00);
      pma_valid <= 1'b0;
      stat();
      `CHK("upper byte", 1'b0, rd[S_ORD_DONE])
      push({8'h5a, ORD_PAT_DEF}, 2'b00);
      pma_valid <= 1'b0;
      stat();
      `CHK("found", 1'b1, rd[S_ORD_DONE])
      axi_wr(REG_CTRL, 32'h300);
      stat();
      `CHK("level only", 1'b1, rd[S_ORD_DONE])
      axi_wr(REG_CTRL, 32'h200);
      axi_wr(REG_CTRL, 32'h300);
      stat();
      `CHK("restart", 1'b0, rd[S_ORD_DONE])
      push({8'h5a, ORD_PAT_DEF}, 2'b00);
      pma_valid <= 1'b0;
      axi_wr(REG_CTRL, 32'h380);
      stat();
      `CHK("pcs reset", 2'b10, {rd[S_FIFO_ERR], rd[S_ORD_DONE]})
      axi_wr(REG_CTRL, 32'h200);
      stop_test();
   end
endmodule
`default_nettype wire

//--- hdl/xcvr_ctrl_pkg.sv
package xcvr_ctrl_pkg;

   // ==========================================================
   // Datapath defaults
   localparam int          CH_W_DEF       = 8;
   localparam int          NCH_DEF        = 1;
   localparam int          FIFO_DEPTH_DEF = 4;
   localparam int          BYTE_W         = 8;
   localparam logic [7:0]  ORD_PAT_DEF    = 8'hbc;
   localparam int          BOND_MIN       = 4;

   // ==========================================================
   // Power states
   localparam logic [1:0]  PS_P0          = 2'h0;
   localparam logic [1:0]  PS_P0S         = 2'h1;
   localparam logic [1:0]  PS_P1          = 2'h2;
   localparam logic [1:0]  PS_P2          = 2'h3;

   // ==========================================================
   // Byte ordering states
   typedef enum logic [2:0] {
      ORD_IDLE = 3'b001,
      ORD_SRCH = 3'b010,
      ORD_DONE = 3'b100
   } ord_st_t;

   // ==========================================================
   // Reconfiguration clock limits, kHz
   localparam int          RCFG_MIN_TX_KHZ = 2500;
   localparam int          RCFG_MIN_RX_KHZ = 37500;
   localparam int          RCFG_MAX_KHZ    = 50000;

   // ==========================================================
   // Register map
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_STATUS = 8'h04;
   localparam logic [7:0]  REG_CMD    = 8'h08;
   localparam logic [7:0]  REG_DATA   = 8'h0c;

   localparam int          C_FORCE_LTD = 0;
   localparam int          C_FORCE_LTR = 1;
   localparam int          C_LPBK      = 2;
   localparam int          C_PLL_PD    = 3;
   localparam int          C_PS_LO     = 4;
   localparam int          C_PS_HI     = 5;
   localparam int          C_IDLE      = 6;
   localparam int          C_RX_RST    = 7;
   localparam int          C_ORD_EN    = 8;
   localparam int          C_DRAIN     = 9;
   localparam int          C_BITS      = 10;
   localparam logic [9:0]  CTRL_RST    = 10'h200;

   localparam int          S_REF_LOCK  = 0;
   localparam int          S_LTD       = 1;
   localparam int          S_PLL_LOCK  = 2;
   localparam int          S_SIGDET    = 3;
   localparam int          S_EIDLE     = 4;
   localparam int          S_ORD_DONE  = 5;
   localparam int          S_FIFO_ERR  = 6;
   localparam int          S_RCFG_OK   = 7;
   localparam int          S_RXCLK     = 8;
   localparam int          S_BONDCLK   = 9;

   localparam int          K_COMPLIANCE = 0;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

//--- hdl/xcvr_fab_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module xcvr_fab_ctrl
   import xcvr_ctrl_pkg::*;
#(
   parameter int ADDR_W     = 8,
   parameter int RCFG_KHZ   = RCFG_MAX_KHZ,
   parameter bit RX_PRESENT = 1'b1
) (
   input  wire logic              aclk,     // Shared zero-offset clock
   input  wire logic              aresetn,  // Sync reset, low
   xcvr_fab_if.fab                fab,      // Transceiver side
   input  wire logic [ADDR_W-1:0] awaddr,   // Write address
   input  wire logic              awvalid,  // Write address valid
   output logic                   awready,  // Write address ready
   input  wire logic [31:0]       wdata,    // Write data
   input  wire logic [3:0]        wstrb,    // Byte strobes
   input  wire logic              wvalid,   // Write data valid
   output logic                   wready,   // Write data ready
   output logic [1:0]             bresp,    // Write response
   output logic                   bvalid,   // Write response valid
   input  wire logic              bready,   // Write response ready
   input  wire logic [ADDR_W-1:0] araddr,   // Read address
   input  wire logic              arvalid,  // Read address valid
   output logic                   arready,  // Read address ready
   output logic [31:0]            rdata,    // Read data
   output logic [1:0]             rresp,    // Read response
   output logic                   rvalid,   // Read data valid
   input  wire logic              rready    // Read data ready
);

   localparam int RCFG_MIN = RX_PRESENT ? RCFG_MIN_RX_KHZ : RCFG_MIN_TX_KHZ;
   localparam bit RCFG_OK  = (RCFG_KHZ >= RCFG_MIN) &&
                             (RCFG_KHZ <= RCFG_MAX_KHZ);

   typedef struct packed {
      logic [C_BITS-1:0] ctrl;
      logic              comp;
      logic [31:0]       word;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
   } st_t;

   st_t         q;
   st_t         d;
   logic        wr_go;
   logic        rd_go;
   logic [31:0] status;
   logic [31:0] wmask;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        off);
      hit = (a[ADDR_W-1:2] == ADDR_W'(off) >> 2);
   endfunction

   // ==========================================================
   // Register access
   always_comb begin
      d      = q;
      wr_go  = awvalid && wvalid && !q.bvalid;
      rd_go  = arvalid && !q.rvalid;
      status = '0;
      status[S_REF_LOCK] = fab.cdr_ref_locked;
      status[S_LTD]      = fab.cdr_ltd_mode;
      status[S_PLL_LOCK] = fab.pll_locked;
      status[S_SIGDET]   = fab.sig_detect;
      status[S_EIDLE]    = fab.elec_idle;
      status[S_ORD_DONE] = fab.ord_done;
      status[S_FIFO_ERR] = fab.rx_fifo_err;
      status[S_RCFG_OK]  = RCFG_OK;
      status[S_RXCLK]    = fab.rx_clk_avail;
      status[S_BONDCLK]  = fab.bond_clk_avail;
      wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

      // Compliance is a single-cycle pulse for the first byte only
      d.comp = 1'b0;
      if (fab.rx_valid) begin
         d.word = 32'(fab.rx_data);
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (wr_go) begin
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         if (hit(awaddr, REG_CTRL)) begin
            d.ctrl = C_BITS'((32'(q.ctrl) & ~wmask) | (wdata & wmask));
         end else if (hit(awaddr, REG_CMD)) begin
            d.comp = wstrb[0] && wdata[K_COMPLIANCE];
         end else if (!hit(awaddr, REG_STATUS) &&
                      !hit(awaddr, REG_DATA)) begin
            d.bresp = RESP_SLVERR;
         end
      end
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         if (hit(araddr, REG_CTRL)) begin
            d.rdata = 32'(q.ctrl);
         end else if (hit(araddr, REG_STATUS)) begin
            d.rdata = status;
         end else if (hit(araddr, REG_DATA)) begin
            d.rdata = q.word;
         end else if (hit(araddr, REG_CMD)) begin
            d.rdata = '0;
         end else begin
            d.rdata = '0;
            d.rresp = RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q      <= '0;
         q.ctrl <= CTRL_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign awready           = wr_go;
   assign wready            = wr_go;
   assign bvalid            = q.bvalid;
   assign bresp             = q.bresp;
   assign arready           = rd_go;
   assign rvalid            = q.rvalid;
   assign rresp             = q.rresp;
   assign rdata             = q.rdata;
   assign fab.force_ltd     = q.ctrl[C_FORCE_LTD];
   assign fab.force_ltr     = q.ctrl[C_FORCE_LTR];
   assign fab.serial_lpbk   = q.ctrl[C_LPBK];
   assign fab.pll_pd        = q.ctrl[C_PLL_PD];
   assign fab.pstate        = q.ctrl[C_PS_HI:C_PS_LO];
   assign fab.tx_force_idle = q.ctrl[C_IDLE];
   assign fab.rx_dig_reset  = q.ctrl[C_RX_RST];
   assign fab.ord_en        = q.ctrl[C_ORD_EN];
   assign fab.rx_ready      = q.ctrl[C_DRAIN];
   assign fab.tx_compliance = q.comp;

endmodule
`default_nettype wire

//--- hdl/xcvr_fab_if.sv
`timescale 1ns/1ps
`default_nettype none
interface xcvr_fab_if #(
   parameter int CH_W = 8,
   parameter int NCH  = 1
);
   localparam int DW = CH_W * NCH;
   localparam int BW = DW / 8;

   logic [DW-1:0] rx_data;
   logic          rx_valid;
   logic          rx_ready;
   logic [BW-1:0] rx_run_disp;
   logic          rx_fifo_err;
   logic          ord_en;
   logic          ord_done;
   logic          cdr_ref_locked;
   logic          cdr_ltd_mode;
   logic          force_ltd;
   logic          force_ltr;
   logic          sig_detect;
   logic          elec_idle;
   logic          serial_lpbk;
   logic          pll_locked;
   logic          pll_pd;
   logic [1:0]    pstate;
   logic          tx_compliance;
   logic          tx_force_idle;
   logic          rx_dig_reset;
   logic          rx_clk_avail;
   logic          bond_clk_avail;

   modport dev (
      output rx_data, rx_valid, rx_run_disp, rx_fifo_err, ord_done,
             cdr_ref_locked, cdr_ltd_mode, sig_detect, elec_idle,
             pll_locked, rx_clk_avail, bond_clk_avail,
      input  rx_ready, ord_en, force_ltd, force_ltr, serial_lpbk,
             pll_pd, pstate, tx_compliance, tx_force_idle, rx_dig_reset
   );
   modport fab (
      input  rx_data, rx_valid, rx_run_disp, rx_fifo_err, ord_done,
             cdr_ref_locked, cdr_ltd_mode, sig_detect, elec_idle,
             pll_locked, rx_clk_avail, bond_clk_avail,
      output rx_ready, ord_en, force_ltd, force_ltr, serial_lpbk,
             pll_pd, pstate, tx_compliance, tx_force_idle, rx_dig_reset
   );
endinterface
`default_nettype wire

//--- hdl/xcvr_rx_dev.sv
// Behaviour
// - Status registered on channel or bonded clock
// - Disparity bit per byte, high negative
// - Byte ordering restarts on enable rising edge
// - Ordering done when pattern seen in LSByte
// - Data width is channel width times channels
// - Recovered clock only without rate-match FIFO
// - Fabric reads FIFO at zero offset clock
// - FIFO error flag when full or empty
// - Reference-lock indicator follows CLK_DATA_RECOVERY reference lock
// - Mode indicator high in lock-to-data
// - Force inputs select auto, reference, data
// - PCIe, no inference: idle is inverted detect
// - Loopback select zero normal, one loopback
// - PLL lock indicator follows PLL lock
// - PLL power-down input stops the PLL
// - Bonded clock only in x4/x8 bonding
// - Reconfiguration clock within documented ranges
// - Power-state code selects four PCIe states
// - Compliance input only on first byte
// - PCIe signals active only in PCIe mode
// - Force idle drives electrical idle levels
// - Digital reset clears receive PCS logic
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module xcvr_rx_dev
   import xcvr_ctrl_pkg::*;
#(
   parameter int         CH_W       = CH_W_DEF,
   parameter int         NCH        = NCH_DEF,
   parameter int         FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter logic [7:0] ORD_PAT    = ORD_PAT_DEF,
   parameter bit         PCIE_MODE  = 1'b1,
   parameter bit         EI_INFER   = 1'b0,
   parameter bit         RATE_MATCH = 1'b0,
   parameter int         BOND       = 1
) (
   input  wire logic                      aclk,          // Channel clock
   input  wire logic                      aresetn,       // Sync reset, low
   xcvr_fab_if.dev                        fab,           // Fabric side
   input  wire logic [CH_W*NCH-1:0]       pma_data,      // Deserialized word
   input  wire logic [CH_W*NCH/8-1:0]     pma_disp,      // Per-byte disparity
   input  wire logic                      pma_valid,     // Word strobe
   input  wire logic                      pma_ref_lock,  // CLK_DATA_RECOVERY near reference
   input  wire logic                      pma_sig_above, // Above threshold
   input  wire logic                      pll_lock_raw,  // Analog PLL lock
   output logic                           cdr_ltd_sel,   // CLK_DATA_RECOVERY to data mode
   output logic                           lpbk_sel,      // Serial loopback
   output logic                           pll_pd_out,    // PLL power-down
   output logic [1:0]                     pstate_out,    // Power state
   output logic                           tx_neg_disp,   // Force neg. disp.
   output logic                           tx_idle_out    // Tx idle levels
);

   localparam int DW = CH_W * NCH;
   localparam int BW = DW / BYTE_W;
   localparam int EW = DW + BW;
   localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   // Count one bit wider than pointers, to tell full from empty
   localparam logic [AW:0] CNT_FULL = (AW+1)'(FIFO_DEPTH);

   // ==========================================================
   // State
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][EW-1:0] mem;
      logic [AW-1:0]                 wp;
      logic [AW-1:0]                 rp;
      logic [AW:0]                   cnt;
      logic [DW-1:0]                 data;
      logic [BW-1:0]                 disp;
      logic                          valid;
      logic                          fifo_err;
      ord_st_t                       ord;
      logic                          ord_en_prev;
      logic                          ref_lk;
      logic                          ltd;
      logic                          sig;
      logic                          eidle;
      logic                          pll_lk;
      logic                          lpbk;
      logic                          pll_pd;
      logic [1:0]                    pstate;
      logic                          neg_disp;
      logic                          idle;
   } st_t;

   st_t q;
   st_t d;
   logic push;
   logic pop;

   // ==========================================================
   // Count decode, shared by the strobes and the error flag
   function automatic logic at_empty(input logic [AW:0] c);
      at_empty = (c == '0);
   endfunction

   function automatic logic at_full(input logic [AW:0] c);
      at_full = (c == CNT_FULL);
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      d    = q;
      pop  = fab.rx_ready && !at_empty(q.cnt);
      push = pma_valid && !at_full(q.cnt);

      // Words arriving while full are dropped; flag shows it
      if (push) begin
         d.mem[q.wp] = {pma_disp, pma_data};
         d.wp        = q.wp + 1'b1;
      end
      d.valid = pop;
      if (pop) begin
         {d.disp, d.data} = q.mem[q.rp];
         d.rp             = q.rp + 1'b1;
      end
      // Push and pop together leave the count as it is
      case ({push, pop})
         2'b10:   d.cnt = q.cnt + 1'b1;
         2'b01:   d.cnt = q.cnt - 1'b1;
         default: d.cnt = q.cnt;
      endcase
      d.fifo_err = at_empty(d.cnt) || at_full(d.cnt);

      // Enable and its copy both reset low: no false edge
      d.ord_en_prev = fab.ord_en;
      case (q.ord)
         ORD_IDLE: d.ord = ORD_IDLE;
         ORD_SRCH: begin
            if (push && (pma_data[BYTE_W-1:0] == ORD_PAT)) begin
               d.ord = ORD_DONE;
            end
         end
         ORD_DONE: d.ord = ORD_DONE;
         // Stray codes fall back to idle
         default:  d.ord = ORD_IDLE;
      endcase
      if (fab.ord_en && !q.ord_en_prev) begin
         d.ord = ORD_SRCH;
      end

      d.ref_lk = pma_ref_lock;
      // Force-data wins whatever force-reference says
      if (fab.force_ltd) begin
         d.ltd = 1'b1;
      end else if (fab.force_ltr) begin
         d.ltd = 1'b0;
      end else begin
         d.ltd = pma_ref_lock;
      end
      d.sig    = pma_sig_above;
      // With inference on, no idle condition is inferred here
      d.eidle  = PCIE_MODE && !EI_INFER && !pma_sig_above;
      d.lpbk   = fab.serial_lpbk;
      d.pll_pd = fab.pll_pd;
      d.pll_lk = pll_lock_raw && !fab.pll_pd;
      d.pstate = PCIE_MODE ? fab.pstate : PS_P0;
      d.neg_disp = PCIE_MODE && fab.tx_compliance;
      d.idle   = fab.tx_force_idle;

      // PCS only; lock and status paths run on
      if (fab.rx_dig_reset) begin
         d.wp       = '0;
         d.rp       = '0;
         d.cnt      = '0;
         d.valid    = 1'b0;
         d.fifo_err = 1'b1;
         d.ord      = ORD_IDLE;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q          <= '0;
         q.ord      <= ORD_IDLE;
         // FIFO starts empty, so its flag starts high
         q.fifo_err <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign fab.rx_data        = q.data;
   assign fab.rx_valid       = q.valid;
   assign fab.rx_run_disp    = q.disp;
   assign fab.rx_fifo_err    = q.fifo_err;
   assign fab.ord_done       = (q.ord == ORD_DONE);
   assign fab.cdr_ref_locked = q.ref_lk;
   assign fab.cdr_ltd_mode   = q.ltd;
   assign fab.sig_detect     = q.sig;
   assign fab.elec_idle      = q.eidle;
   assign fab.pll_locked     = q.pll_lk;
   // No clocks are made here; only their presence is shown
   assign fab.rx_clk_avail   = !RATE_MATCH;
   assign fab.bond_clk_avail = (BOND >= BOND_MIN);
   assign cdr_ltd_sel        = q.ltd;
   assign lpbk_sel           = q.lpbk;
   assign pll_pd_out         = q.pll_pd;
   assign pstate_out         = q.pstate;
   assign tx_neg_disp        = q.neg_disp;
   assign tx_idle_out        = q.idle;

endmodule
`default_nettype wire
